/* File: tb/rtcsp_host_tb.sv */
// Self-checking bench for the two-wire host against the register port model.
// Assumes pull-ups on both lines; the model starts with a fixed pattern in its array.
`timescale 1ns/10ps
module rtcsp_host_tb;
    import rtcsp_pkg::*;
    localparam logic [6:0] SLAVE_ID = 7'h3C; // Arbitrary value
    logic sys_clk, rst_b, cmd_valid, cmd_ready, rd_valid, rd_ready, busy, done, nack;
    logic scl_o, scl_oe_n, sda_o, sda_oe_n, scl_pull, sda_pull, scl_w, sda_w, slow;
    logic [6:0] dev_id;
    logic [7:0] got_addr, tx_cnt, start_cnt, exp_ptr;
    logic [7:0] exp_mem [0:31];
    rtcsp_cmd_type cmd;
    rtcsp_rd_type rd_word;
    int fails, checks_done, words;
    // Released lines float to the pull-up level
    assign scl_w = (scl_oe_n | scl_o) & ~scl_pull;
    assign sda_w = (sda_oe_n | sda_o) & ~sda_pull;
    rtcsp_host #(.DEV_ID(SLAVE_ID)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd(cmd), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_word(rd_word),
        .busy(busy), .done(done), .nack(nack), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
    rtcsp_slave_model #(.PWR_CYC(20)) slave_u (.sys_clk(sys_clk), .rst_b(rst_b), .dev_id(dev_id),
        .slow(slow), .scl(scl_w), .sda(sda_w), .scl_pull(scl_pull), .sda_pull(sda_pull),
        .got_addr(got_addr), .tx_cnt(tx_cnt), .start_cnt(start_cnt));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] next_ptr(input logic [7:0] p);
        return (p == PTR_LAST) ? PTR_RESET : p + 8'h01;
    endfunction
    function automatic logic [7:0] init_byte(input int i);
        return 8'h5A ^ 8'(i * 3);
    endfunction
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Entered just after an edge; returns just after the edge that saw done
    task automatic run(input logic rd, input logic cur, input logic [7:0] ra, input logic [7:0] wd,
            input logic [4:0] len);
        int n;
        cmd = '{rd, cur, ra, wd, len};
        cmd_valid = 1'b1;
        n = 0;
        do begin @(posedge sys_clk); n++; end while (cmd_ready !== 1'b1 && n < 100);
        #1;
        cmd_valid = 1'b0;
        #20;
        check(busy, 16'h1);
        n = 0;
        do begin @(posedge sys_clk); n++; end while (done !== 1'b1 && n < 60000);
        #1;
        if (n >= 60000) begin
            fails++;
            $display("Error at %0t: transfer never finished", $time);
        end
    endtask
    always @(posedge sys_clk) begin
        if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
            check(rd_word.addr, {8'h00, exp_ptr});
            check(rd_word.data, {8'h00, exp_mem[exp_ptr[4:0]]});
            exp_ptr = next_ptr(exp_ptr);
            words++;
        end
    end
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // About 77k cycles of traffic are expected; stop at 100k
    initial begin
        #1000000;
        fails++;
        $display("Error at %0t: watchdog expired", $time);
        summarize();
    end
    initial begin
        int base, w0, s0;
        logic [7:0] ra, wd;
        void'($urandom(32'h5564));
        {rst_b, cmd_valid, cmd, slow, fails, checks_done, words} = '0;
        rd_ready = 1'b1;
        dev_id = SLAVE_ID;
        exp_ptr = PTR_RESET;
        for (int i = 0; i < 32; i++) exp_mem[i] = init_byte(i);
        repeat (2) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        check({cmd_ready, busy, scl_oe_n, sda_oe_n}, 16'hB);
        repeat (30) @(posedge sys_clk);
        #1;
        run(1'b1, 1'b1, 8'h00, 8'h00, 5'h00); // Current read straight after reset
        check(16'(words), 16'h1);
        check(got_addr, {8'h00, SLAVE_ID, DIR_RD});
        check({start_cnt, 7'h00, nack}, 16'h0100);
        for (int k = 0; k < 3; k++) begin
            slow = (k == 2);
            ra = (k == 0) ? 8'h1F : (8'h1B + 8'($urandom_range(16))) & 8'h1F;
            wd = 8'($urandom);
            run(1'b0, 1'b0, ra, wd, 5'h00);
            exp_mem[ra[4:0]] = wd;
            check(got_addr, {8'h00, SLAVE_ID, DIR_WR});
            check(nack, 16'h0);
        end
        slow = 1'b0;
        dev_id = SLAVE_ID ^ 7'h01;
        run(1'b0, 1'b0, 8'h05, 8'hFF, 5'h00); // Unmatched address must drop the write
        check(nack, 16'h1);
        dev_id = SLAVE_ID;
        // Long read with the consumer stalled: FIFO fills, bus is held
        rd_ready = 1'b0;
        exp_ptr = 8'h1B;
        base = tx_cnt;
        w0 = words;
        s0 = start_cnt;
        fork
            run(1'b1, 1'b0, 8'h1B, 8'h00, 5'd16);
            begin
                while (tx_cnt < 8'(base + FIFO_DEPTH)) @(posedge sys_clk);
                repeat (3000) @(posedge sys_clk);
                check({busy, scl_w, tx_cnt}, {2'h3, 8'(base + FIFO_DEPTH)});
                check(16'(words - w0), 16'h0);
                #1 rd_ready = 1'b1;
            end
        join
        check(16'(words - w0), 16'd17);
        check(tx_cnt, 8'(base + 17));
        check(start_cnt, 8'(s0 + 2));
        check(got_addr, {8'h00, SLAVE_ID, DIR_RD});
        summarize();
    end
endmodule // rtcsp_host_tb

/* File: tb/rtcsp_slave_model.sv */
// Behavioural model of the clock chip's two-wire register port, 32 locations.
// Assumes the bench resolves both open-drain lines with pull-ups; runs off the bench clock.
`timescale 1ns/10ps
module rtcsp_slave_model #(
    parameter int unsigned PWR_CYC = 20,
    // Status location and flag positions are arbitrary in this model
    parameter logic [4:0] STAT_LOC = 5'h07,
    parameter int unsigned FIRST_ALARM_FLAG = 0,
    parameter int unsigned SECOND_ALARM_FLAG = 1,
    parameter logic ALARM_FLAG_AUTO_CLEAR = 1'b1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Behaviour controls
    input wire logic [6:0] dev_id,
    input wire logic slow,
    // Bus lines
    input wire logic scl,
    input wire logic sda,
    output logic scl_pull,
    output logic sda_pull,
    // Observation
    output logic [7:0] got_addr,
    output logic [7:0] tx_cnt,
    output logic [7:0] start_cnt
);
    logic [7:0] mem [0:31];
    logic [7:0] sh;
    logic [7:0] ptr;
    logic [3:0] bitn;
    logic [1:0] ph; // 0 address, 1 pointer, 2 write data, 3 transmit
    logic act;
    logic mack;
    logic stat_rd;
    logic pull;
    logic scl_p;
    logic sda_p;
    int pwr;
    int stretch;
    // Pins change by non-blocking assignment so the host never races the model
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 32; i++) begin
                mem[i] = 8'h5A ^ 8'(i * 3);
            end
            ptr = 8'h00;
            pull = 1'b0;
            sda_pull <= 1'b0;
            scl_pull <= 1'b0;
            got_addr <= 8'h00;
            tx_cnt <= 8'h00;
            start_cnt <= 8'h00;
            {sh, bitn, ph, act, mack, stat_rd} = '0;
            {scl_p, sda_p} = 2'h3;
            pwr = 0;
            stretch = 0;
        end else begin
            if (pwr < PWR_CYC) pwr++;
            if (stretch > 0) stretch--;
            if (scl && scl_p && sda_p && !sda && pwr >= PWR_CYC) begin
                act = 1'b1;
                ph = 2'h0;
                // The clock fall that ends a start opens bit zero
                bitn = 4'hF;
                pull = 1'b0;
                stat_rd = 1'b0;
                start_cnt <= start_cnt + 8'h01;
            end else if (scl && scl_p && !sda_p && sda) begin
                act = 1'b0;
                pull = 1'b0;
                if (stat_rd && ALARM_FLAG_AUTO_CLEAR) begin
                    mem[STAT_LOC][FIRST_ALARM_FLAG] = 1'b0;
                    mem[STAT_LOC][SECOND_ALARM_FLAG] = 1'b0;
                end
                stat_rd = 1'b0;
            end else if (act && !scl_p && scl) begin
                if (bitn < 4'h8) sh = {sh[6:0], sda};
                else mack = !sda;
            end else if (act && scl_p && !scl) begin
                // Stretch longer than three quarters so the host really waits
                if (slow) stretch = 200;
                if (bitn == 4'h7) begin
                    bitn = 4'h8;
                    pull = (ph != 2'h3);
                    if (ph == 2'h0) begin
                        got_addr <= sh;
                        if (sh[7:1] != dev_id) begin
                            act = 1'b0;
                            pull = 1'b0;
                        end
                    end else if (ph == 2'h1) begin
                        ptr = sh;
                    end else if (ph == 2'h2) begin
                        mem[ptr[4:0]] = sh;
                    end else begin
                        tx_cnt <= tx_cnt + 8'h01;
                        if (ptr[4:0] == STAT_LOC) stat_rd = 1'b1;
                        ptr = (ptr == 8'h1F) ? 8'h00 : ptr + 8'h01;
                    end
                end else if (bitn == 4'h8) begin
                    bitn = 4'h0;
                    pull = 1'b0;
                    if (ph == 2'h0) ph = sh[0] ? 2'h3 : 2'h1;
                    else if (ph == 2'h1) ph = 2'h2;
                    else if (ph == 2'h3 && !mack) act = 1'b0;
                    if (act && ph == 2'h3) pull = !mem[ptr[4:0]][7];
                end else begin
                    bitn++;
                    if (ph == 2'h3) pull = !mem[ptr[4:0]][7 - bitn];
                end
            end
            scl_p = scl;
            sda_p = sda;
            sda_pull <= pull;
            scl_pull <= (stretch > 0);
        end
    end
endmodule // rtcsp_slave_model

/* File: verilog/rtcsp_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; one clock, asynchronous active-low reset.
`timescale 1ns/10ps
module rtcsp_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [AW:0] wr_q, rd_q;
    logic [WIDTH-1:0] mem_q [DEPTH];
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire empty = wr_q == rd_q;

    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_q[rd_q[AW-1:0]];

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_entry
            always_ff @(posedge sys_clk) begin
                if (push && wr_q[AW-1:0] == AW'(i)) begin
                    mem_q[i] <= in_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (AW+1)'(push);
            rd_q <= rd_q + (AW+1)'(pop);
        end
    end
endmodule // rtcsp_fifo

/* File: verilog/rtcsp_host.sv */
// Bus master that drives the clock chip's two-wire register port.
// Assumes pull-ups on both lines; read bytes leave through a 16-word FIFO.
`timescale 1ns/10ps
module rtcsp_host import rtcsp_pkg::*; #(
    parameter logic [6:0] DEV_ID = 7'h2A // Arbitrary value
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire rtcsp_cmd_type cmd,
    // Read data
    output logic rd_valid,
    input wire logic rd_ready,
    output rtcsp_rd_type rd_word,
    // Status
    output logic busy,
    output logic done,
    output logic nack,
    // Bus pins
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n
);
    rtcsp_state_type st_q, st_d;
    rtcsp_cmd_type cmd_q;
    logic [CNT_W-1:0] cnt_q;
    logic [1:0] qtr_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q, sh_d, ptr_q;
    logic [4:0] left_q;
    logic scl_m_q, scl_s_q, sda_m_q, sda_s_q;
    logic scl_q, sda_q, nack_q, done_q, again_q;
    logic push_rdy;

    // Pin synchronisers
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
        end
    end

    // Quarter timing; a slave holding clock low only delays the high quarters
    wire idle = st_q == ST_IDLE;
    wire cnt_done = cnt_q == QTR_LAST;
    wire stretch = qtr_q >= QTR_HIGH && !scl_s_q;
    wire push_v = st_q == ST_READ && bit_q == BIT_LAST_DATA && qtr_q == QTR_END && cnt_done;
    // A full FIFO parks the clock high after the eighth bit, before any ack
    wire tick = cnt_done && !stretch && !(push_v && !push_rdy);
    wire q_end = tick && qtr_q == QTR_END;
    wire sample = tick && qtr_q == QTR_HIGH;
    wire is_byte = st_q inside {ST_ADDRW, ST_REG, ST_DATA, ST_ADDRR, ST_READ};
    wire tx = is_byte && st_q != ST_READ;
    wire ack_bit = bit_q == BIT_ACK;
    wire byte_end = q_end && is_byte && ack_bit;
    wire acked = !nack_q;
    wire accept = cmd_valid && idle;
    wire [CNT_W-1:0] cnt_d = (idle || tick) ? '0 : (cnt_done ? cnt_q : cnt_q + CNT_W'(1));
    wire [7:0] ptr_inc = (ptr_q == PTR_LAST) ? PTR_RESET : ptr_q + 8'h01;

    // Line levels; quarter 0 holds data while the clock falls
    wire bit_lvl = ack_bit ? (tx ? 1'b1 : (left_q == 5'h00)) : (tx ? sh_q[7] : 1'b1);
    wire lvl = (st_q == ST_START) ? (qtr_q != QTR_END) : (st_q == ST_STOP) ? (qtr_q == QTR_END) : bit_lvl;
    wire sda_d = idle ? 1'b1 : ((qtr_q == QTR_HOLD) ? sda_q : lvl);
    wire scl_d = idle || qtr_q >= QTR_HIGH;
    wire rx_shift = sample && st_q == ST_READ && !ack_bit;
    wire tx_shift = q_end && tx && !ack_bit;
    wire nack_set = sample && tx && ack_bit && sda_s_q;
    // Read bit only for read commands, so a stray cur flag cannot turn a write
    wire [7:0] id_byte = {DEV_ID, cmd_q.rd && (again_q || cmd_q.cur)};

    // Next state at the end of each start, byte and stop
    always_comb begin
        st_d = st_q;
        sh_d = sh_q;
        case (st_q)
            ST_IDLE: begin
                if (cmd_valid) begin
                    st_d = ST_START;
                end
            end
            ST_START: begin
                if (q_end) begin
                    st_d = (cmd_q.rd && (cmd_q.cur || again_q)) ? ST_ADDRR : ST_ADDRW;
                    sh_d = id_byte;
                end
            end
            ST_ADDRW: begin
                if (byte_end) begin
                    st_d = acked ? ST_REG : ST_STOP;
                    sh_d = cmd_q.reg_addr;
                end
            end
            ST_REG: begin
                if (byte_end) begin
                    st_d = !acked ? ST_STOP : (cmd_q.rd ? ST_START : ST_DATA);
                    sh_d = cmd_q.wdata;
                end
            end
            ST_DATA: begin
                if (byte_end) begin
                    st_d = ST_STOP;
                end
            end
            ST_ADDRR: begin
                if (byte_end) begin
                    st_d = acked ? ST_READ : ST_STOP;
                end
            end
            ST_READ: begin
                if (byte_end && left_q == 5'h00) begin
                    st_d = ST_STOP;
                end
            end
            ST_STOP: begin
                if (q_end) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
        if (tx_shift) begin
            sh_d = {sh_q[6:0], 1'b1};
        end else if (rx_shift) begin
            sh_d = {sh_q[6:0], sda_s_q};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= ST_IDLE;
            cnt_q <= '0;
            qtr_q <= QTR_HOLD;
            bit_q <= BIT_FIRST;
            sh_q <= 8'h00;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            qtr_q <= idle ? QTR_HOLD : qtr_q + 2'(tick);
            bit_q <= (!is_byte || byte_end) ? BIT_FIRST : bit_q + 4'(q_end);
            sh_q <= sh_d;
            scl_q <= scl_d;
            sda_q <= sda_d;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_q <= '0;
            left_q <= 5'h00;
            ptr_q <= PTR_RESET;
            nack_q <= 1'b0;
            done_q <= 1'b0;
            again_q <= 1'b0;
        end else begin
            if (accept) begin
                cmd_q <= cmd;
            end
            if (accept) begin
                left_q <= cmd.len;
            end else if (byte_end && st_q == ST_READ) begin
                left_q <= left_q - 5'h01;
            end
            if (byte_end && st_q == ST_REG) begin
                ptr_q <= cmd_q.reg_addr;
            end else if (push_v && push_rdy) begin
                ptr_q <= ptr_inc;
            end
            nack_q <= nack_set || (nack_q && !accept);
            done_q <= q_end && st_q == ST_STOP;
            again_q <= (byte_end && st_q == ST_REG) || (again_q && !idle);
        end
    end

    rtcsp_fifo #(
        .WIDTH(RD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .in_valid(push_v),
        .in_ready(push_rdy),
        .in_data({ptr_q, sh_q}),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_word)
    );

    assign cmd_ready = idle;
    assign busy = !idle;
    assign done = done_q;
    assign nack = nack_q;
    // Open drain: pins only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_n = scl_q;
    assign sda_oe_n = sda_q;

    localparam int STOP_WAIT = 80;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    property p_change_low;
        $changed(sda_q) && scl_q && $past(scl_q) |-> $past(st_q) inside {ST_START, ST_STOP};
    endproperty
    a_change_low: assert property (p_change_low) else $error("data moved while clock high");
    property p_msb_first;
        st_q == ST_ADDRW && bit_q == BIT_FIRST && qtr_q == QTR_HIGH |-> sda_q == DEV_ID[6];
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first bit is not the msb");
    property p_dir_bit;
        st_q inside {ST_ADDRW, ST_ADDRR} && bit_q == BIT_LAST_DATA && qtr_q == QTR_HIGH
            |-> sda_q == (st_q == ST_ADDRR);
    endproperty
    a_dir_bit: assert property (p_dir_bit) else $error("wrong direction bit");
    property p_release_ack;
        tx && ack_bit && qtr_q == QTR_HIGH |-> sda_oe_n;
    endproperty
    a_release_ack: assert property (p_release_ack) else $error("data held during slave ack");
    property p_master_ack;
        st_q == ST_READ && ack_bit && qtr_q == QTR_HIGH |-> sda_oe_n == (left_q == 5'h00);
    endproperty
    a_master_ack: assert property (p_master_ack) else $error("wrong host ack");
    property p_stop_end;
        done_q |-> idle && scl_q && sda_q ##1 scl_oe_n && sda_oe_n;
    endproperty
    a_stop_end: assert property (p_stop_end) else $error("transfer did not end in stop");
    property p_idle_free;
        idle && $past(idle) |-> sda_oe_n && scl_oe_n;
    endproperty
    a_idle_free: assert property (p_idle_free) else $error("line driven while idle");
    property p_ptr_wrap;
        push_v && push_rdy && ptr_q == PTR_LAST |=> ptr_q == PTR_RESET;
    endproperty
    a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap");
    property p_nack_stop;
        nack_set |-> ##[1:STOP_WAIT] st_q == ST_STOP;
    endproperty
    a_nack_stop: assert property (p_nack_stop) else $error("no stop after nack");
    property p_reg_byte;
        st_q == ST_REG && bit_q == BIT_FIRST && qtr_q == QTR_HIGH |-> sda_q == cmd_q.reg_addr[7];
    endproperty
    a_reg_byte: assert property (p_reg_byte) else $error("register byte wrong");

    c_write: cover property (done_q && !cmd_q.rd && !nack_q);
    c_burst: cover property (push_v && push_rdy && left_q == 5'h00 && cmd_q.len != 5'h00);
    c_nack: cover property ($rose(nack_q));
    c_stall: cover property (push_v && !push_rdy);
endmodule // rtcsp_host

/* File: verilog/rtcsp_pkg.sv */
// Constants and types shared by the serial host for the clock chip's register port.
// Assumes a 100 MHz system clock and a fast-mode two-wire bus.
package rtcsp_pkg;
    localparam int unsigned SYS_CLK_KHZ = 100000;
    localparam int unsigned SCL_KHZ = 400;
    // One bit is four quarters; a quarter is a least time, so it rounds up
    localparam int unsigned QTR_CYC = (SYS_CLK_KHZ + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
    localparam int unsigned CNT_W = 7;
    localparam logic [CNT_W-1:0] QTR_LAST = CNT_W'(QTR_CYC - 1);
    localparam logic [1:0] QTR_HOLD = 2'h0;
    localparam logic [1:0] QTR_HIGH = 2'h2;
    localparam logic [1:0] QTR_END = 2'h3;
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_LAST_DATA = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic DIR_RD = 1'b1;
    localparam logic DIR_WR = 1'b0;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] PTR_LAST = 8'h1F;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned RD_W = 2 * BYTE_W;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_START = 4'h1,
        ST_ADDRW = 4'h3,
        ST_REG = 4'h2,
        ST_DATA = 4'h6,
        ST_ADDRR = 4'h7,
        ST_READ = 4'h5,
        ST_STOP = 4'h4
    } rtcsp_state_type;

    // len is the number of read bytes minus one
    typedef struct packed {
        logic rd;
        logic cur;
        logic [7:0] reg_addr;
        logic [7:0] wdata;
        logic [4:0] len;
    } rtcsp_cmd_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } rtcsp_rd_type;
endpackage
